//--- axp_cfg.svh
`ifndef AXP_CFG_SVH
`define AXP_CFG_SVH

// External drive mode field encodings
`define AXP_MODE_OFF    2'h0
`define AXP_MODE_CONT   2'h1
`define AXP_MODE_FIXED  2'h2
`define AXP_MODE_PULSAR 2'h3

// Quadrature divide ratio encodings
`define AXP_DIV_1       2'h0
`define AXP_DIV_2       2'h1
`define AXP_DIV_4       2'h2

// Prescaler masks per divide ratio
`define AXP_PRE_FULL    2'h0
`define AXP_PRE_HALF    2'h1
`define AXP_PRE_QUART   2'h3

// Counter and synchroniser shapes
`define AXP_POS_W       32
`define AXP_POS_RST     32'h0000_0000
`define AXP_POS_ONE     32'h0000_0001
`define AXP_SYNC_W      4
`define AXP_SYNC_RST    4'hF

`endif

//--- axp_pkg.sv
`default_nettype none
package axp_pkg;
    // Which drive mode, fixed or continuous, owns the running external drive
    typedef enum logic [1:0] {
        AXP_IDLE,
        AXP_FIXED_RUN,
        AXP_CONT_RUN
    } axp_state_type;
endpackage
`default_nettype wire

//--- axp_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "axp_cfg.svh"
module axp_sync import axp_pkg::*; (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    // Raw pins and synchronised copies
    input  wire logic [`AXP_SYNC_W-1:0] pin_in,
    output logic      [`AXP_SYNC_W-1:0] pin_sync
);
    logic [`AXP_SYNC_W-1:0] meta_q;
    logic [`AXP_SYNC_W-1:0] sync_q;

    localparam logic [`AXP_SYNC_W-1:0] SYNC_RST = `AXP_SYNC_RST;

    genvar i;
    generate
        for (i = 0; i < `AXP_SYNC_W; i++) begin : g_bit
            // Idle high so no false trigger edge leaves reset
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_q[i] <= SYNC_RST[i];
                    sync_q[i] <= SYNC_RST[i];
                end else begin
                    meta_q[i] <= pin_in[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign pin_sync = sync_q;
endmodule
`default_nettype wire

//--- axp_quad.sv
`timescale 1ns/1ps
`default_nettype none
`include "axp_cfg.svh"
module axp_quad import axp_pkg::*; (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Synchronised phases
    input  wire logic phase_a,
    input  wire logic phase_b,
    // Decoded steps, one cycle each
    output logic      step_up,
    output logic      step_dn,
    output logic      rise_a,
    output logic      rise_b
);
    logic a_q;
    logic b_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_q <= 1'b1;
            b_q <= 1'b1;
        end else begin
            a_q <= phase_a;
            b_q <= phase_b;
        end
    end

    // Both phases moving at once is an illegal jump and counts nothing
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if ((a_q ^ phase_a) != (b_q ^ phase_b)) begin
            step_up = (phase_a ^ b_q);
            step_dn = (phase_b ^ a_q);
        end
    end

    assign rise_a = phase_a & ~a_q;
    assign rise_b = phase_b & ~b_q;
endmodule
`default_nettype wire

//--- axp_axis.sv
// What this block does
// - Mode 1,0: falling plus trigger starts a plus fixed drive.
// - Mode 1,0: falling minus trigger starts a minus fixed drive.
// - Further trigger falls are ignored while a triggered fixed drive runs.
// - Mode 0,1: falling trigger starts continuous drive in its direction.
// - Trigger back high: decelerating stop if trapezoidal, else sudden stop.
// - Mode 1,1 is manual pulsar: A on plus trigger, B on minus.
// - Pulsar: A rising with B low starts a minus fixed drive.
// - Pulsar: each A edge starts a drive of P pulses.
// - Two-pulse type: plus pulses on plus pin, minus on other.
// - Pulse-direction type: pulses on plus pin, direction high for minus.
// - Pulse type select chooses two-pulse or pulse-direction output.
// - Pulse and direction polarity bits set active output levels.
// - Quadrature mode: A leading counts up, B leading counts down.
// - Quadrature mode counts every edge of both phases.
// - Counter reverse bit swaps up and down counting.
// - Quadrature counts may be divided by two or four.
// - Up/down mode: rising up input increments, rising down decrements.
`timescale 1ns/1ps
`default_nettype none
`include "axp_cfg.svh"
module axp_axis import axp_pkg::*; (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // External trigger and encoder pins
    input  wire logic                  ext_plus_trigger,
    input  wire logic                  ext_minus_trigger,
    input  wire logic                  enc_a_up_in,
    input  wire logic                  enc_b_down_in,
    // Mode bits
    input  wire logic [1:0]            ext_drive_mode,
    input  wire logic                  pulse_type_select,
    input  wire logic                  pulse_polarity,
    input  wire logic                  dir_polarity,
    input  wire logic                  input_type_select,
    input  wire logic [1:0]            input_divide_ratio,
    input  wire logic                  counter_reverse,
    input  wire logic                  trapezoid_drive,
    // Drive generator side
    input  wire logic                  drive_pulse,
    input  wire logic                  drive_done,
    output logic                       start_fixed,
    output logic                       start_cont,
    output logic                       drive_minus,
    output logic                       stop_decel,
    output logic                       stop_sudden,
    // Motor driver pins
    output logic                       plus_pulse_out,
    output logic                       minus_pulse_dir_out,
    // Real position counter
    output logic [`AXP_POS_W-1:0]      real_pos
);
    logic [`AXP_SYNC_W-1:0] pin_s;
    logic                   plus_s;
    logic                   minus_s;
    logic                   plus_prev_q;
    logic                   minus_prev_q;
    logic                   fall_p;
    logic                   fall_m;
    logic                   rise_p;
    logic                   rise_m;
    axp_state_type          state_q;
    logic                   start_fixed_q;
    logic                   start_cont_q;
    logic                   dir_q;
    logic                   stop_decel_q;
    logic                   stop_sudden_q;
    logic                   pls_q;
    logic                   dir_out_q;
    logic                   q_up;
    logic                   q_dn;
    logic                   ea_rise;
    logic                   eb_rise;
    logic                   raw_up;
    logic                   raw_dn;
    logic                   cnt_up;
    logic                   cnt_dn;
    logic [1:0]             pre_q;
    logic [1:0]             pre_mask;
    logic [`AXP_POS_W-1:0]  pos_q;

    // Mask of the quadrature prescaler for the selected ratio
    function automatic logic [1:0] div_mask(input logic [1:0] ratio);
        unique case (ratio)
            `AXP_DIV_1: div_mask = `AXP_PRE_FULL;
            `AXP_DIV_2: div_mask = `AXP_PRE_HALF;
            default:    div_mask = `AXP_PRE_QUART;
        endcase
    endfunction

    axp_sync u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .pin_in   ({enc_b_down_in, enc_a_up_in, ext_minus_trigger, ext_plus_trigger}),
        .pin_sync (pin_s)
    );

    axp_quad u_quad (
        .clk     (clk),
        .arst_n  (arst_n),
        .phase_a (pin_s[2]),
        .phase_b (pin_s[3]),
        .step_up (q_up),
        .step_dn (q_dn),
        .rise_a  (ea_rise),
        .rise_b  (eb_rise)
    );

    assign plus_s  = pin_s[0];
    assign minus_s = pin_s[1];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            plus_prev_q  <= 1'b1;
            minus_prev_q <= 1'b1;
        end else begin
            plus_prev_q  <= plus_s;
            minus_prev_q <= minus_s;
        end
    end

    assign fall_p = plus_prev_q & ~plus_s;
    assign fall_m = minus_prev_q & ~minus_s;
    assign rise_p = ~plus_prev_q & plus_s;
    assign rise_m = ~minus_prev_q & minus_s;

    // Drive start and stop sequencing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q       <= AXP_IDLE;
            start_fixed_q <= 1'b0;
            start_cont_q  <= 1'b0;
            dir_q         <= 1'b0;
            stop_decel_q  <= 1'b0;
            stop_sudden_q <= 1'b0;
        end else begin
            start_fixed_q <= 1'b0;
            start_cont_q  <= 1'b0;
            stop_decel_q  <= 1'b0;
            stop_sudden_q <= 1'b0;
            unique case (state_q)
                AXP_IDLE: begin
                    if (ext_drive_mode == `AXP_MODE_FIXED && (fall_p || fall_m)) begin
                        start_fixed_q <= 1'b1;
                        dir_q         <= ~fall_p;
                        state_q       <= AXP_FIXED_RUN;
                    end else if (ext_drive_mode == `AXP_MODE_CONT && (fall_p || fall_m)) begin
                        start_cont_q <= 1'b1;
                        dir_q        <= ~fall_p;
                        state_q      <= AXP_CONT_RUN;
                    end else if (ext_drive_mode == `AXP_MODE_PULSAR && (rise_p || fall_p)) begin
                        // Same quadrature sense on either A edge
                        start_fixed_q <= 1'b1;
                        dir_q         <= rise_p ? ~minus_s : minus_s;
                    end
                end
                AXP_FIXED_RUN: begin
                    // New falls are dropped until the generator reports done
                    if (drive_done) begin
                        state_q <= AXP_IDLE;
                    end
                end
                AXP_CONT_RUN: begin
                    if ((dir_q ? rise_m : rise_p) || ext_drive_mode != `AXP_MODE_CONT) begin
                        stop_decel_q  <= trapezoid_drive;
                        stop_sudden_q <= ~trapezoid_drive;
                        state_q       <= AXP_IDLE;
                    end
                end
            endcase
        end
    end

    assign start_fixed = start_fixed_q;
    assign start_cont  = start_cont_q;
    assign drive_minus = dir_q;
    assign stop_decel  = stop_decel_q;
    assign stop_sudden = stop_sudden_q;

    // Output formatting; polarity bit set means active low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pls_q     <= 1'b0;
            dir_out_q <= 1'b0;
        end else if (pulse_type_select) begin
            pls_q     <= drive_pulse ^ pulse_polarity;
            dir_out_q <= dir_q ^ dir_polarity;
        end else begin
            pls_q     <= (drive_pulse & ~dir_q) ^ pulse_polarity;
            dir_out_q <= (drive_pulse & dir_q) ^ pulse_polarity;
        end
    end

    assign plus_pulse_out      = pls_q;
    assign minus_pulse_dir_out = dir_out_q;

    // Count sources; up and down together cancel
    assign raw_up = input_type_select ? (ea_rise & ~eb_rise) : q_up;
    assign raw_dn = input_type_select ? (eb_rise & ~ea_rise) : q_dn;
    assign pre_mask = input_type_select ? `AXP_PRE_FULL : div_mask(input_divide_ratio);

    // Up/down prescaler: no drift when direction dithers on one edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= 2'h0;
        end else if (raw_up != raw_dn) begin
            pre_q <= (raw_up ? pre_q + 2'h1 : pre_q - 2'h1) & pre_mask;
        end else begin
            pre_q <= pre_q & pre_mask;
        end
    end

    assign cnt_up = (counter_reverse ? raw_dn : raw_up)
                  & ((counter_reverse ? 2'h0 : pre_mask) == (pre_q & pre_mask));
    assign cnt_dn = (counter_reverse ? raw_up : raw_dn)
                  & ((counter_reverse ? pre_mask : 2'h0) == (pre_q & pre_mask));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pos_q <= `AXP_POS_RST;
        end else if (cnt_up && !cnt_dn) begin
            pos_q <= pos_q + `AXP_POS_ONE;
        end else if (cnt_dn && !cnt_up) begin
            pos_q <= pos_q - `AXP_POS_ONE;
        end
    end

    assign real_pos = pos_q;

    a_fixed_start: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == AXP_IDLE && ext_drive_mode == `AXP_MODE_FIXED && fall_p)
        |=> (start_fixed && !drive_minus && state_q == AXP_FIXED_RUN))
        else $error("fixed plus start missing");

    a_fixed_minus: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == AXP_IDLE && ext_drive_mode == `AXP_MODE_FIXED && fall_m && !fall_p)
        |=> (start_fixed && drive_minus))
        else $error("fixed minus start missing");

    a_fixed_ignore: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == AXP_FIXED_RUN && !drive_done) |=> !start_fixed && !start_cont)
        else $error("start during running fixed drive");

    a_cont_start: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == AXP_IDLE && ext_drive_mode == `AXP_MODE_CONT && fall_m && !fall_p)
        |=> (start_cont && drive_minus && state_q == AXP_CONT_RUN))
        else $error("continuous minus start missing");

    a_cont_stop: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == AXP_CONT_RUN && !dir_q && rise_p)
        |=> (stop_decel == $past(trapezoid_drive)) && (stop_sudden != stop_decel))
        else $error("continuous stop kind wrong");

    a_pulsar_dir: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == AXP_IDLE && ext_drive_mode == `AXP_MODE_PULSAR && rise_p)
        |=> start_fixed && (drive_minus == !$past(minus_s)))
        else $error("pulsar direction wrong");

    a_pulsar_fall: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == AXP_IDLE && ext_drive_mode == `AXP_MODE_PULSAR && fall_p) |=> start_fixed)
        else $error("pulsar falling edge lost");

    a_two_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        (!pulse_type_select && !pulse_polarity && dir_q)
        |=> !plus_pulse_out && (minus_pulse_dir_out == $past(drive_pulse)))
        else $error("two-pulse minus routing wrong");

    a_pulse_dir: assert property (@(posedge clk) disable iff (!arst_n)
        (pulse_type_select && !dir_polarity) |=> (minus_pulse_dir_out == $past(dir_q)))
        else $error("direction output wrong");

    a_quad_count: assert property (@(posedge clk) disable iff (!arst_n)
        (!input_type_select && input_divide_ratio == `AXP_DIV_1 && !counter_reverse && q_up)
        |=> (real_pos == $past(pos_q) + `AXP_POS_ONE))
        else $error("quadrature step not counted");

    a_reverse: assert property (@(posedge clk) disable iff (!arst_n)
        (input_type_select && counter_reverse && ea_rise && !eb_rise)
        |=> (real_pos == $past(pos_q) - `AXP_POS_ONE))
        else $error("reverse count wrong");

    a_updown: assert property (@(posedge clk) disable iff (!arst_n)
        (input_type_select && !counter_reverse && eb_rise && !ea_rise)
        |=> (real_pos == $past(pos_q) - `AXP_POS_ONE))
        else $error("down input not counted");
endmodule
`default_nettype wire

//--- axp_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module axp_far_model #(
    parameter int PULSES = 3
) (
    // Clock
    input  wire logic clk,
    // Generator requests
    input  wire logic start_fixed,
    input  wire logic start_cont,
    input  wire logic stop_decel,
    input  wire logic stop_sudden,
    // Generator answers
    output logic      drive_pulse,
    output logic      drive_done,
    // Trigger and encoder pins, idle high
    output logic      ext_plus_trigger,
    output logic      ext_minus_trigger,
    output logic      enc_a_up_in,
    output logic      enc_b_down_in
);
    logic stop_seen;
    initial begin
        {drive_pulse, drive_done} = 2'h0;
        {ext_plus_trigger, ext_minus_trigger, enc_a_up_in, enc_b_down_in} = 4'hF;
        stop_seen = 1'b0;
    end
    always @(posedge clk) if (stop_decel || stop_sudden) stop_seen = 1'b1;
    // Pulse train with a gap, so the pins show real edges
    task automatic one_pulse();
        // Even spacing, no ramp: start rate equals drive rate
        @(negedge clk) drive_pulse = 1'b1;
        @(negedge clk) drive_pulse = 1'b0;
        @(negedge clk);
    endtask
    initial forever begin
        @(posedge clk);
        if (start_fixed === 1'b1) begin
            repeat (PULSES) one_pulse();
            @(negedge clk) drive_done = 1'b1;
            @(negedge clk) drive_done = 1'b0;
        end else if (start_cont === 1'b1) begin
            stop_seen = 1'b0;
            while (!stop_seen) one_pulse();
        end
    end
    // Trigger levels held for hold clocks, as short as one
    task automatic set_trig(input logic p, input logic m, input int hold);
        @(negedge clk) {ext_plus_trigger, ext_minus_trigger} = {p, m};
        repeat (hold) @(negedge clk);
    endtask
    // Full encoder cycles; up means phase A leads
    task automatic quad(input bit up, input int n);
        logic [1:0] seq [4];
        if (up) begin
            seq = '{2'h1, 2'h0, 2'h2, 2'h3};
        end else begin
            seq = '{2'h2, 2'h0, 2'h1, 2'h3};
        end
        repeat (n) for (int i = 0; i < 4; i++) begin
            @(negedge clk) {enc_a_up_in, enc_b_down_in} = seq[i];
            repeat (5) @(negedge clk);
        end
    endtask
    task automatic updown(input bit up, input int n);
        repeat (n) begin
            @(negedge clk) if (up) enc_a_up_in = 1'b0; else enc_b_down_in = 1'b0;
            repeat (5) @(negedge clk);
            {enc_a_up_in, enc_b_down_in} = 2'h3;
            repeat (5) @(negedge clk);
        end
    endtask
endmodule
`default_nettype wire

//--- axp_axis_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "axp_cfg.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
    $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module axp_axis_bench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] mode = `AXP_MODE_OFF;
    logic pt = 1'b0, pp = 1'b0, dp = 1'b0, its = 1'b0, rev = 1'b0, trap = 1'b0;
    logic [1:0] dv = `AXP_DIV_1;
    wire logic dpl, ddn, sf, sc, dm, sd, ss, po, mo, ep, em, ea, eb;
    wire logic [`AXP_POS_W-1:0] pos;
    int err_total = 0, n_tests = 0;
    int n_fix, n_cont, n_dec, n_sud, n_po, n_mo;
    logic last_dir, po_q, mo_q;
    logic [`AXP_POS_W-1:0] base;

    always #20 clk = ~clk;

    axp_axis DUT (.clk(clk), .arst_n(arst_n), .ext_plus_trigger(ep), .ext_minus_trigger(em),
        .enc_a_up_in(ea), .enc_b_down_in(eb), .ext_drive_mode(mode), .pulse_type_select(pt),
        .pulse_polarity(pp), .dir_polarity(dp), .input_type_select(its),
        .input_divide_ratio(dv), .counter_reverse(rev), .trapezoid_drive(trap),
        .drive_pulse(dpl), .drive_done(ddn), .start_fixed(sf), .start_cont(sc),
        .drive_minus(dm), .stop_decel(sd), .stop_sudden(ss), .plus_pulse_out(po),
        .minus_pulse_dir_out(mo), .real_pos(pos));
    axp_far_model #(.PULSES(3)) fm (.clk(clk), .start_fixed(sf), .start_cont(sc),
        .stop_decel(sd), .stop_sudden(ss), .drive_pulse(dpl), .drive_done(ddn),
        .ext_plus_trigger(ep), .ext_minus_trigger(em), .enc_a_up_in(ea),
        .enc_b_down_in(eb));

    // Active-edge counters, polarity folded in so inverted pins count alike
    always @(posedge clk) begin
        po_q <= po ^ pp;
        mo_q <= mo ^ pp;
        if (sf === 1'b1) begin n_fix++; last_dir <= dm; end
        if (sc === 1'b1) begin n_cont++; last_dir <= dm; end
        if (sd === 1'b1) n_dec++;
        if (ss === 1'b1) n_sud++;
        if ((po ^ pp) === 1'b1 && po_q === 1'b0) n_po++;
        if ((mo ^ pp) === 1'b1 && mo_q === 1'b0) n_mo++;
    end

    task automatic clr();
        n_fix  = 0;
        n_cont = 0;
        n_dec  = 0;
        n_sud  = 0;
        n_po   = 0;
        n_mo   = 0;
    endtask

    // Second fall lands inside the running drive and must be dropped
    task automatic t_fixed(input bit minus);
        mode = `AXP_MODE_FIXED; pt = 1'b0; pp = 1'b0; clr();
        fm.set_trig(minus, !minus, 6);
        fm.set_trig(1'b1, 1'b1, 1);
        fm.set_trig(!minus, minus, 6);
        fm.set_trig(1'b1, 1'b1, 30);
        `CHK("fixed starts", 1, n_fix)
        `CHK("fixed dir", minus, last_dir)
        `CHK("plus pin pulses", minus ? 0 : 3, n_po)
        `CHK("minus pin pulses", minus ? 3 : 0, n_mo)
    endtask

    task automatic t_cont();
        mode = `AXP_MODE_CONT; trap = 1'b0; clr();
        fm.set_trig(1'b1, 1'b0, 10);
        `CHK("cont start", 1, n_cont)
        `CHK("cont dir", 1'b1, last_dir)
        fm.set_trig(1'b1, 1'b1, 10);
        `CHK("sudden stop", 1, n_sud)
        trap = 1'b1;
        fm.set_trig(1'b0, 1'b1, 10);
        `CHK("cont dir plus", 1'b0, last_dir)
        fm.set_trig(1'b1, 1'b1, 10);
        `CHK("decel stop", 1, n_dec)
        `CHK("cont total", 2, n_cont)
        // Leaving continuous mode mid-drive must stop it
        fm.set_trig(1'b0, 1'b1, 10);
        mode = `AXP_MODE_OFF;
        repeat (10) @(negedge clk);
        `CHK("mode change stop", 2, n_dec)
        fm.set_trig(1'b1, 1'b1, 6);
        fm.set_trig(1'b0, 1'b1, 10);
        fm.set_trig(1'b1, 1'b1, 10);
        `CHK("no start when off", 3, n_cont + n_fix)
    endtask

    // Each phase A edge starts one fixed drive; B level picks direction
    task automatic t_pulsar();
        mode = `AXP_MODE_PULSAR; pt = 1'b0; pp = 1'b0; clr();
        fm.set_trig(1'b1, 1'b0, 20);
        `CHK("B alone starts", 0, n_fix)
        // Edges spaced well beyond one burst of pulses
        fm.set_trig(1'b0, 1'b0, 20);
        `CHK("A fall B low dir", 1'b0, last_dir)
        fm.set_trig(1'b1, 1'b0, 20);
        `CHK("A rise B low dir", 1'b1, last_dir)
        fm.set_trig(1'b0, 1'b1, 20);
        `CHK("A fall B high dir", 1'b1, last_dir)
        fm.set_trig(1'b1, 1'b1, 20);
        `CHK("A rise B high dir", 1'b0, last_dir)
        `CHK("pulsar starts", 4, n_fix)
        `CHK("pulsar pulses", 12, n_po + n_mo)
        mode = `AXP_MODE_OFF;
    endtask

    task automatic t_dirtype();
        mode = `AXP_MODE_FIXED; pt = 1'b1; dp = 1'b0; pp = 1'b0; clr();
        fm.set_trig(1'b1, 1'b0, 6);
        fm.set_trig(1'b1, 1'b1, 30);
        `CHK("pls pin pulses", 3, n_po)
        // Direction pin settles once to minus and carries no pulses
        `CHK("dir pin rises", 1, n_mo)
        `CHK("dir pin minus", 1'b1, mo)
        pp = 1'b1; dp = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("pulse idle inverted", 1'b1, po)
        `CHK("dir inverted", 1'b0, mo)
        pt = 1'b0; pp = 1'b0; dp = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("two-pulse idle", 1'b0, mo)
    endtask

    task automatic pos_step(input bit up, input int n, input int delta, input string nm);
        base = pos;
        if (its) fm.updown(up, n); else fm.quad(up, n);
        repeat (5) @(negedge clk);
        `CHK(nm, base + delta, pos)
    endtask

    task automatic t_counter();
        its = 1'b0; rev = 1'b0; dv = `AXP_DIV_1;
        pos_step(1'b1, 2, 8, "quad up");
        pos_step(1'b0, 1, -4, "quad down");
        rev = 1'b1;
        pos_step(1'b1, 2, -8, "quad reversed");
        rev = 1'b0; dv = `AXP_DIV_2;
        pos_step(1'b1, 4, 8, "quad half");
        dv = `AXP_DIV_4;
        pos_step(1'b0, 4, -4, "quad quarter");
        its = 1'b1;
        pos_step(1'b1, 3, 3, "up pulses");
        pos_step(1'b0, 2, -2, "down pulses");
        rev = 1'b1;
        pos_step(1'b1, 2, -2, "up pulses reversed");
        rev = 1'b0;
        its = 1'b0; dv = `AXP_DIV_1;
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Scenarios need under a thousand cycles; allow ample margin
    initial begin
        #(40 * 20000);
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_fixed(1'b0);
        t_fixed(1'b1);
        t_cont();
        t_pulsar();
        t_dirtype();
        t_counter();
        tally_and_finish();
    end
endmodule
`default_nettype wire
